/* File: core/evp_consts.svh */
/*
 * Constants of the exception vector priority decoder: register offsets,
 * field positions, reset values and the fixed vector map.
 * Assumes inclusion by bare name from the design files under core/.
 */
`ifndef EVP_CONSTS_SVH
`define EVP_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define EVP_OFS_VBASE     4'h0
`define EVP_OFS_STATUS    4'h4
`define EVP_OFS_LASTVEC   4'h8
`define EVP_OFS_SPURCNT   4'hC

// Vector base: upper byte after reset and forced in debug, and the fixed low byte
`define EVP_VBASE_RESET   8'hFF
`define EVP_VBASE_FORCED  8'hFF
`define EVP_VBASE_LOW     8'h00

// Fixed reset vectors, independent of the base register
`define EVP_VEC_POR       16'hFFFE
`define EVP_VEC_CLKMON    16'hFFFC
`define EVP_VEC_WDOG      16'hFFFA

// Low-byte offsets relative to the vector base
`define EVP_OFS_TRAP      8'hF8
`define EVP_OFS_SOFT      8'hF6
`define EVP_OFS_HIGH      8'hF4
`define EVP_OFS_NORM0     8'h82
`define EVP_OFS_SPUR      8'h80

// Status register field positions
`define EVP_ST_NM_PEND    0
`define EVP_ST_HIGH_PEND  1
`define EVP_ST_TRAP_PEND  2
`define EVP_ST_SOFT_PEND  3
`define EVP_ST_WAKE       4
`define EVP_ST_CLASS_LSB  8

`endif

/* File: core/evp_decoder.sv */
/*
 * Exception vector priority decoder: ranks reset, trap, soft, high and
 * normal requests and hands the CPU the winning vector on request.
 * Assumes one clock mclk, inputs synchronous to it except where they
 * only feed the clockless wake path, and an Avalon-MM master.
 */
`default_nettype none

`include "evp_consts.svh"

// How the decoder behaves, for whoever integrates it next
//
// Sampling
// All request lines are plain levels, taken on the mclk edge at which
// the CPU strobe vec_req is high. Nothing is latched ahead of the
// strobe, so a request that drops before it is never seen, and a
// request that rises just before it can still take over the fetch.
// This is why sources must hold their line until their handler runs.
//
// Ranking
// The three reset lines come first and always give their fixed
// top-of-memory vectors. Then come the trap, the soft request and the
// high-priority request, in that order. The normal lines follow, the
// pin line above all device lines, and within the device lines the
// highest index wins. With nothing left the spurious vector is given.
//
// Masking
// The high mask only keeps the high request from winning; a masked
// high request neither wins nor holds back the normal lines. The
// normal mask keeps every normal line out, and so does any pending
// trap, soft request or unmasked high request.
//
// Vector base
// The base byte comes from the base register, or is forced to all
// ones while background debug runs, so the debug firmware always
// finds its handlers at the top of memory. The low byte is the offset
// of the winning class. Reset vectors never look at the base.
//
// Answer timing
// The vector, its valid pulse and its spurious flag come from flops,
// one edge after the strobe. The vector then holds until the next
// strobe, so the CPU may read it late; the pulses last as long as the strobe.
// A strobe held high simply recaptures the winner on every edge.
//
// Wake-up
// The wake output is a pure gate network on the request lines, their
// enables and the normal mask flag. It must work with every clock stopped, so it has no flop;
// it is the one output of this block that is not registered. A user
// must therefore expect it to glitch as request lines settle, and
// should synchronise it wherever it meets a running clock.
//
// Register bus
// Every beat costs exactly one wait cycle. Read data is loaded during
// that wait cycle and then stands when waitrequest drops, so the
// master takes it on the same edge at which it sees the answer. The
// price is one cycle per beat, traded for a read path with no
// combinational route from address to readdata.
//
// Register map
// Offset 0x0 holds the base byte, resetting to all ones. Offset 0x4
// shows the live pending view and the class of the last vector.
// Offset 0x8 mirrors the last vector handed over. Offset 0xC counts
// spurious fetches and saturates; any write with byte lane 0 set
// clears it, and a fetch in the same cycle still counts as one.
// Unmapped offsets read as zero and ignore writes.
//
// Limits
// Only byte lane 0 of a write matters; upper data bits are ignored.
// The number of device lines is the NUM_SRC parameter; their offsets
// climb two bytes per line from the lowest normal slot, so the width
// is bounded by the space below the high request's slot.
//
module evp_decoder
    import evp_pkg::*;
#(
    parameter int NUM_SRC = 56
) (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output var  logic [31:0]        avs_readdata,
    output var  logic               avs_waitrequest,
    input  wire logic               rst_por_req,
    input  wire logic               rst_clkmon_req,
    input  wire logic               rst_watchdog_req,
    input  wire logic               trap_req,
    input  wire logic               soft_interrupt_req,
    input  wire logic               pin_high_prio_request,
    input  wire logic               ext_irq_req,
    input  wire logic               ext_irq_en,
    input  wire logic [NUM_SRC-1:0] src_req,
    input  wire logic [NUM_SRC-1:0] src_en,
    input  wire logic               i_mask,
    input  wire logic               x_mask,
    input  wire logic               debug_active,
    input  wire logic               vec_req,
    output var  logic [15:0]        vector_addr,
    output var  logic               vector_valid,
    output var  logic               vector_spurious,
    output wire logic               wake_req
);
    localparam int W  = NUM_SRC + 1;
    localparam int IW = $clog2(W);

    // Offset of normal line idx: two bytes per line above the first slot
    function automatic logic [7:0] nm_offset(input logic [IW-1:0] idx);
        logic [8:0] sum;
        sum = {1'b0, `EVP_OFS_NORM0} + {8'(idx), 1'b0};
        return sum[7:0];
    endfunction

    // Full vector from the base byte and a low-byte offset
    function automatic logic [15:0] rel_vec(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, `EVP_VBASE_LOW} + {8'h00, lo};
    endfunction

    // Registers
    logic [7:0]    vbase_r;
    logic [7:0]    vbase_nxt;
    logic          wait_r;
    logic [31:0]   rdata_r;
    logic [15:0]   vec_r;
    logic          vec_valid_r;
    logic          spur_r;
    evp_class_type class_r;
    logic [7:0]    spur_cnt_r;
    logic [7:0]    spur_cnt_nxt;

    evp_req_if #(.W(W)) rq ();

    // Leaves: fixed-priority encoder and the clockless wake path
    evp_prio #(
        .W (W)
    ) u_prio (
        .rq (rq.prio)
    );

    evp_wake u_wake (
        .rq (rq.wk)
    );

    // Request qualification
    wire [W-1:0] nm_raw;
    wire         high_qual;
    wire         nm_block;
    wire         nm_open;

    // Pin line sits on top so it outranks every device source
    assign nm_raw    = {ext_irq_req & ext_irq_en, src_req & src_en};
    // A masked high request is not pending towards the CPU
    assign high_qual = pin_high_prio_request & ~x_mask;
    assign nm_block  = trap_req | soft_interrupt_req | high_qual;
    // Mask flag set inside a normal routine keeps other normals out
    assign nm_open   = ~i_mask & ~nm_block;

    assign rq.nm_raw   = nm_raw;
    assign rq.nm_qual  = nm_raw & {W{nm_open}};
    assign rq.high_req = pin_high_prio_request;
    assign rq.i_mask   = i_mask;

    // Wake stays combinational; a flop here would never clock in stop
    assign wake_req = rq.wake;

    // Vector base byte, overridden while background debug runs
    wire [7:0] base_hi;

    assign base_hi = debug_active ? `EVP_VBASE_FORCED : vbase_r;

    // Winner selection, highest vector first
    evp_class_type win_class;

    always_comb begin
        if (rst_por_req) begin
            win_class = EVP_CL_POR;
        end else if (rst_clkmon_req) begin
            win_class = EVP_CL_CLKMON;
        end else if (rst_watchdog_req) begin
            win_class = EVP_CL_WDOG;
        end else if (trap_req) begin
            win_class = EVP_CL_TRAP;
        end else if (soft_interrupt_req) begin
            win_class = EVP_CL_SOFT;
        end else if (high_qual) begin
            win_class = EVP_CL_HIGH;
        end else if (rq.nm_found) begin
            win_class = EVP_CL_NORMAL;
        end else begin
            win_class = EVP_CL_SPUR;
        end
    end

    // Vector of the winning class
    logic [15:0] win_vec;

    always_comb begin
        case (win_class)
            EVP_CL_POR:    win_vec = `EVP_VEC_POR;
            EVP_CL_CLKMON: win_vec = `EVP_VEC_CLKMON;
            EVP_CL_WDOG:   win_vec = `EVP_VEC_WDOG;
            EVP_CL_TRAP:   win_vec = rel_vec(base_hi, `EVP_OFS_TRAP);
            EVP_CL_SOFT:   win_vec = rel_vec(base_hi, `EVP_OFS_SOFT);
            EVP_CL_HIGH:   win_vec = rel_vec(base_hi, `EVP_OFS_HIGH);
            EVP_CL_NORMAL: win_vec = rel_vec(base_hi, nm_offset(rq.nm_idx));
            default:       win_vec = rel_vec(base_hi, `EVP_OFS_SPUR);
        endcase
    end

    // Vector capture: decided from the requests present at the strobe,
    // so a later, higher request displaces the one that was recognised
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vec_r       <= `EVP_VEC_POR;
            vec_valid_r <= 1'b0;
            spur_r      <= 1'b0;
            class_r     <= EVP_CL_SPUR;
        end else begin
            vec_valid_r <= vec_req;
            spur_r      <= vec_req & (win_class == EVP_CL_SPUR);
            if (vec_req) begin
                vec_r   <= win_vec;
                class_r <= win_class;
            end
        end
    end

    assign vector_addr     = vec_r;
    assign vector_valid    = vec_valid_r;
    assign vector_spurious = spur_r;

    // Bus decode; a write takes effect only while waitrequest is low
    wire bus_req;
    wire bus_do;
    wire wr_vbase;
    wire wr_spurcnt;
    wire spur_event;

    assign bus_req    = avs_read | avs_write;
    assign bus_do     = avs_write & ~wait_r;
    assign wr_vbase   = bus_do & (avs_address == `EVP_OFS_VBASE) & avs_byteenable[0];
    assign wr_spurcnt = bus_do & (avs_address == `EVP_OFS_SPURCNT) & avs_byteenable[0];
    assign spur_event = vec_req & (win_class == EVP_CL_SPUR);

    // Base register: software write steers the vector table location
    assign vbase_nxt = wr_vbase ? avs_writedata[7:0] : vbase_r;

    // Spurious counter: a write clears it, but a same-cycle event still
    // counts, so no spurious vector is lost to the clear; saturates at all ones
    always_comb begin
        spur_cnt_nxt = spur_cnt_r;
        if (wr_spurcnt) begin
            spur_cnt_nxt = 8'h00;
        end
        if (spur_event && (spur_cnt_nxt != 8'hFF)) begin
            spur_cnt_nxt = spur_cnt_nxt + 8'h01;
        end
    end

    // Status word: live pending view and class of the last vector
    wire [31:0] status_word;

    assign status_word = {16'h0000, class_r, 3'b000,
                          rq.wake, soft_interrupt_req, trap_req, high_qual, rq.nm_found};

    // Read data selection; unmapped offsets read as zero
    logic [31:0] rd_mux;

    always_comb begin
        case (avs_address)
            `EVP_OFS_VBASE:   rd_mux = {24'h00_0000, vbase_r};
            `EVP_OFS_STATUS:  rd_mux = status_word;
            `EVP_OFS_LASTVEC: rd_mux = {16'h0000, vec_r};
            `EVP_OFS_SPURCNT: rd_mux = {24'h00_0000, spur_cnt_r};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Register state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vbase_r    <= `EVP_VBASE_RESET;
            spur_cnt_r <= 8'h00;
        end else begin
            vbase_r    <= vbase_nxt;
            spur_cnt_r <= spur_cnt_nxt;
        end
    end

    // Bus handshake: one wait cycle, then a single low cycle per beat.
    // Read data is loaded in the wait cycle so it stands with the answer.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r  <= ~(bus_req & wait_r);
            if (avs_read && wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;

endmodule

`default_nettype wire

/* File: core/evp_pkg.sv */
/*
 * Types of the exception vector priority decoder.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package evp_pkg;

    // Class of the winning exception, one-hot, highest priority first
    typedef enum logic [7:0] {
        EVP_CL_POR    = 8'h80,
        EVP_CL_CLKMON = 8'h40,
        EVP_CL_WDOG   = 8'h20,
        EVP_CL_TRAP   = 8'h10,
        EVP_CL_SOFT   = 8'h08,
        EVP_CL_HIGH   = 8'h04,
        EVP_CL_NORMAL = 8'h02,
        EVP_CL_SPUR   = 8'h01
    } evp_class_type;

endpackage

`default_nettype wire

/* File: core/evp_prio.sv */
/*
 * Fixed priority encoder over the normally maskable lines.
 * Assumes line i sits at a vector offset that rises with i.
 */
`default_nettype none

module evp_prio #(
    parameter int W = 57
) (
    evp_req_if.prio rq
);
    // Later lines overwrite earlier ones, so the highest index wins
    always_comb begin
        rq.nm_found = 1'b0;
        rq.nm_idx   = '0;
        for (int i = 0; i < W; i++) begin
            if (rq.nm_qual[i]) begin
                rq.nm_found = 1'b1;
                rq.nm_idx   = i[$bits(rq.nm_idx)-1:0];
            end
        end
    end
endmodule

`default_nettype wire

/* File: core/evp_req_if.sv */
/*
 * Carrier between the decoder top and its priority and wake-up leaves.
 * Assumes W equals the count of normally maskable lines, pin line included.
 */
`default_nettype none

interface evp_req_if #(
    parameter int W  = 57,
    parameter int IW = $clog2(W)
) ();
    logic [W-1:0]  nm_raw;      // Request and local enable, unmasked
    logic [W-1:0]  nm_qual;     // Fully qualified normal requests
    logic          high_req;    // Raw high-priority maskable request
    logic          i_mask;      // Normal mask flag
    logic          nm_found;
    logic [IW-1:0] nm_idx;
    logic          wake;

    modport top  (output nm_raw, nm_qual, high_req, i_mask,
                  input nm_found, nm_idx, wake);
    modport prio (input nm_qual, output nm_found, nm_idx);
    modport wk   (input nm_raw, high_req, i_mask, output wake);
endinterface

`default_nettype wire

/* File: core/evp_wake.sv */
/*
 * Clockless wake-up qualification for stop and wait.
 * Assumes request lines that can change while all clocks stand still.
 */
`default_nettype none

module evp_wake (
    evp_req_if.wk rq
);
    wire nm_wake;
    wire high_wake;

    // Same enable and mask test as in run mode; no flop on the path
    assign nm_wake   = (|rq.nm_raw) & ~rq.i_mask;
    // High mask flag does not block a wake; the CPU then skips the handler
    assign high_wake = rq.high_req;
    assign rq.wake   = nm_wake | high_wake;
endmodule

`default_nettype wire

/* File: tb/evp_cpu_model.sv */
/*
 * CPU side model: raises the vector strobe for one cycle on command and
 * takes the answer. Assumes the bench pulses go for one cycle at a time.
 */
`default_nettype none

module evp_cpu_model (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic        vector_valid,
    input  wire logic        vector_spurious,
    input  wire logic [15:0] vector_addr,
    output var  logic        vec_req,
    output var  logic        got,
    output var  logic        got_spur,
    output var  logic [15:0] got_vec
);
    timeunit 1ns;
    timeprecision 1ns;

    initial vec_req = 1'b0;

    // The vector stands valid one cycle only, so it is taken right then
    always @(posedge mclk) begin
        vec_req <= go;
        got     <= vector_valid;
        if (vector_valid) begin
            got_vec  <= vector_addr;
            got_spur <= vector_spurious;
        end
    end
endmodule

`default_nettype wire

/* File: tb/evp_decoder_asserts.sv */
/*
 * Port checks of the vector decoder, bound to every decoder instance.
 * Assumes one clock mclk and the asynchronous active-low resetn.
 */
`default_nettype none

module evp_decoder_asserts (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        rst_por_req,
    input wire logic        rst_clkmon_req,
    input wire logic        rst_watchdog_req,
    input wire logic        trap_req,
    input wire logic        soft_interrupt_req,
    input wire logic        pin_high_prio_request,
    input wire logic        i_mask,
    input wire logic        x_mask,
    input wire logic        debug_active,
    input wire logic        vec_req,
    input wire logic [15:0] vector_addr,
    input wire logic        vector_valid,
    input wire logic        vector_spurious,
    input wire logic        wake_req
);
    timeunit 1ns;
    timeprecision 1ns;

    // Request classes that outrank the normal lines
    wire logic rst_any = rst_por_req | rst_clkmon_req | rst_watchdog_req;
    wire logic high_q  = pin_high_prio_request & ~x_mask;
    wire logic strobe  = vec_req & ~rst_any;
    wire logic no_ts   = ~trap_req & ~soft_interrupt_req;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Answer timing: a valid pulse exists only because of a strobe
    valid_lat_a: assert property (vec_req |=> vector_valid)
        else $error("vector valid missing after strobe");
    valid_cause_a: assert property (vector_valid |-> $past(vec_req))
        else $error("vector valid without strobe");
    // Reset vectors are fixed, whatever the base or debug state
    por_vec_a: assert property (vec_req && rst_por_req |=> vector_addr == 16'hFFFE)
        else $error("power-on vector wrong");
    clkmon_vec_a: assert property (vec_req && !rst_por_req && rst_clkmon_req
        |=> vector_addr == 16'hFFFC) else $error("clock monitor vector wrong");
    wdog_vec_a: assert property (strobe == 1'b0 && vec_req && rst_watchdog_req
        && !rst_por_req && !rst_clkmon_req |=> vector_addr == 16'hFFFA)
        else $error("watchdog vector wrong");
    // Non-normal classes in fixed order, each above the normal lines
    trap_vec_a: assert property (strobe && trap_req
        |=> vector_addr[7:0] == 8'hF8 && !vector_spurious) else $error("trap vector wrong");
    soft_vec_a: assert property (strobe && !trap_req && soft_interrupt_req
        |=> vector_addr[7:0] == 8'hF6) else $error("soft vector wrong");
    high_vec_a: assert property (strobe && no_ts && high_q
        |=> vector_addr[7:0] == 8'hF4) else $error("high vector wrong");
    // A set normal mask leaves nothing but the spurious vector; debug forces the base byte to all ones
    mask_norm_a: assert property (strobe && no_ts && !high_q && i_mask
        |=> vector_spurious && vector_addr[7:0] == 8'h80) else $error("masked normal won");
    debug_base_a: assert property (strobe && debug_active
        |=> vector_addr[15:8] == 8'hFF) else $error("debug base not forced");
    // Wake-up needs no clock edge, sampled here only for checking
    wake_mask_a: assert property (i_mask && !pin_high_prio_request |-> !wake_req)
        else $error("wake while masked");
    wake_high_a: assert property (pin_high_prio_request |-> wake_req)
        else $error("high request gave no wake");

    // Main scenarios reached
    cover property (vec_req && trap_req);
    cover property (vector_spurious);
    cover property (wake_req && x_mask && pin_high_prio_request);
endmodule

bind evp_decoder evp_decoder_asserts evp_decoder_asserts_inst (
    .mclk, .resetn, .rst_por_req, .rst_clkmon_req, .rst_watchdog_req, .trap_req,
    .soft_interrupt_req, .pin_high_prio_request, .i_mask, .x_mask, .debug_active,
    .vec_req, .vector_addr, .vector_valid, .vector_spurious, .wake_req
);

`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * Self-checking bench of the vector decoder: bus tasks, vector fetches
 * through the CPU model, request patterns with expected vectors.
 * Assumes the decoder under core/ and the checker bound to it.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int NS = 56;
    logic             mclk = 1'b0;
    logic             run = 1'b1;
    logic             resetn = 1'b0;
    logic [3:0]       avs_address = 4'h0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0000_0000;
    logic [3:0]       avs_byteenable = 4'h1;
    logic [6:0]       rq = 7'h00;
    logic [NS-1:0]    src_req = '0;
    logic [NS-1:0]    src_en = '1;
    logic             ext_irq_en = 1'b1;
    logic             i_mask = 1'b0;
    logic             x_mask = 1'b0;
    logic             debug_active = 1'b0;
    logic             go = 1'b0;
    logic [31:0]      q;
    logic [15:0]      e;
    int               n_mismatch = 0;
    int               total_checks = 0;
    wire logic        rst_por_req, rst_clkmon_req, rst_watchdog_req, trap_req;
    wire logic        soft_interrupt_req, pin_high_prio_request, ext_irq_req, vec_req;
    wire logic        avs_waitrequest, vector_valid, vector_spurious, wake_req;
    wire logic        got, got_spur;
    wire logic [31:0] avs_readdata;
    wire logic [15:0] vector_addr, got_vec;

    // Request lines in rank order, power-on reset first
    assign {rst_por_req, rst_clkmon_req, rst_watchdog_req, trap_req, soft_interrupt_req,
            pin_high_prio_request, ext_irq_req} = rq;

    evp_decoder #(.NUM_SRC(NS)) evp_decoder_inst (
        .mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .rst_por_req, .rst_clkmon_req,
        .rst_watchdog_req, .trap_req, .soft_interrupt_req, .pin_high_prio_request,
        .ext_irq_req, .ext_irq_en, .src_req, .src_en, .i_mask, .x_mask, .debug_active,
        .vec_req, .vector_addr, .vector_valid, .vector_spurious, .wake_req);
    evp_cpu_model evp_cpu_model_inst (
        .mclk, .go, .vector_valid, .vector_spurious, .vector_addr, .vec_req, .got,
        .got_spur, .got_vec);

    // Gated so the wake path can be seen with the clock standing still
    initial forever #50 if (run) mclk = ~mclk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        total_checks++;
        if (s !== ex) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, s);
        end
    endtask

    // One Avalon beat, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~w;
        avs_write <= w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // One vector fetch through the CPU model
    task automatic vec(input logic [15:0] ex, input logic sp);
        @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        do @(posedge mclk); while (got !== 1'b1);
        chk("vector", 32'(ex), 32'(got_vec));
        chk("spurious", 32'(sp), 32'(got_spur));
    endtask

    initial begin
        #1_000_000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk("reset vector", 32'h0000_FFFE, 32'(vector_addr));
        bus(1'b0, 4'h0, 32'h0000_0000, q);
        chk("base reset", 32'h0000_00FF, q);
        vec(16'hFF80, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0040, q);
        bus(1'b0, 4'h0, 32'h0000_0000, q);
        chk("base", 32'h0000_0040, q);
        bus(1'b0, 4'h2, 32'h0000_0000, q);
        chk("unmapped", 32'h0000_0000, q);
        // Pending sets shrink from the top: each winner is the highest left
        src_req <= '1;
        for (int k = 0; k < 8; k++) begin
            rq <= 7'h7F >> k;
            e = (k < 3) ? 16'hFFFE - 16'(2 * k) : {8'h40, 8'hF8 - 8'(2 * k - 6)};
            vec(e, 1'b0);
        end
        for (int i = 0; i < NS; i += 11) begin
            src_req <= NS'(1) << i;
            vec({8'h40, 8'h82 + 8'(2 * i)}, 1'b0);
        end
        src_req <= (NS'(1) << 3) | (NS'(1) << 20);
        src_en <= NS'(1) << 3;
        vec(16'h4088, 1'b0);
        // A later, higher request takes over the fetch
        src_req <= NS'(1);
        src_en <= '1;
        repeat (3) @(posedge mclk);
        rq <= 7'h01;
        vec(16'h40F2, 1'b0);
        rq <= 7'h02;
        i_mask <= 1'b1;
        vec(16'h40F4, 1'b0);
        x_mask <= 1'b1;
        vec(16'h4080, 1'b1);
        #1 chk("wake high", 32'h0000_0001, 32'(wake_req));
        rq <= 7'h00;
        vec(16'h4080, 1'b1);
        #1 chk("wake masked", 32'h0000_0000, 32'(wake_req));
        i_mask <= 1'b0;
        vec(16'h4082, 1'b0);
        debug_active <= 1'b1;
        vec(16'hFF82, 1'b0);
        src_req <= '0;
        vec(16'hFF80, 1'b1);
        bus(1'b0, 4'hC, 32'h0000_0000, q);
        chk("spurious count", 32'h0000_0004, q);
        bus(1'b0, 4'h8, 32'h0000_0000, q);
        chk("last vector", 32'h0000_FF80, q);
        bus(1'b0, 4'h4, 32'h0000_0000, q);
        chk("status", 32'h0000_0100, q);
        bus(1'b1, 4'hC, 32'h0000_0000, q);
        bus(1'b0, 4'hC, 32'h0000_0000, q);
        chk("count cleared", 32'h0000_0000, q);
        // Clock stopped: the wake output must still follow the lines
        run <= 1'b0;
        #200 src_req <= NS'(1);
        #10 chk("wake stopped", 32'h0000_0001, 32'(wake_req));
        src_en <= '0;
        #10 chk("wake no enable", 32'h0000_0000, 32'(wake_req));
        tally_and_finish();
    end
endmodule

`default_nettype wire
